// ---- mmu_address_translation_protection_tb.sv ----
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin fails++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module mmu_address_translation_protection_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys, resetn, acc_req, acc_code, acc_sfr, irq_level, ans_valid, acc_grant, nmi;
    logic        tbl_wr, tbl_rd, tbl_rvalid, mmu_enabled, n;
    logic [15:0] log_addr, tbl_wdata, tbl_rdata;
    logic [23:0] phys_addr, pa;
    logic [5:0]  tbl_idx;
    logic [1:0]  st;
    logic [16:0] q;
    int          fails = 0, checked = 0, cycles = 0;
    mmu_unit i_dut (.clk_sys, .resetn, .acc_req, .acc_code, .acc_sfr, .log_addr, .irq_level, .ans_valid,
        .acc_grant, .phys_addr, .nmi, .tbl_wr, .tbl_rd, .tbl_idx, .tbl_wdata, .tbl_rdata, .tbl_rvalid,
        .mmu_enabled);
    mmu_cpu_model i_cpu (.clk_sys, .acc_req, .acc_code, .acc_sfr, .log_addr, .irq_level, .ans_valid,
        .acc_grant, .phys_addr, .nmi, .tbl_wr, .tbl_rd, .tbl_idx, .tbl_wdata, .tbl_rdata, .tbl_rvalid);
    initial clk_sys = 1'b0;
    always #10 clk_sys = ~clk_sys;
    task automatic end_sim;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // the whole run needs under a hundred cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            end_sim();
        end
    end
    task automatic t_transparent;
        i_cpu.set_mode(1'b1);
        `CHK(mmu_enabled, 1'b0)
        i_cpu.acc(1'b0, 1'b0, 16'hBEEF, st, pa, n);
        `CHK({st, pa, n}, {2'b11, 24'h00BEEF, 1'b0})
        i_cpu.set_mode(1'b0);
        i_cpu.acc(1'b1, 1'b0, 16'h0123, st, pa, n);
        `CHK({st, pa, n}, {2'b11, 24'h000123, 1'b0})
        i_cpu.set_mode(1'b1);
        i_cpu.tbl(1'b0, mmu_pkg::IDX_CTRL, 16'h0000, q, n);
        `CHK({q, n}, {17'h10000, 1'b0})
    endtask
    task automatic t_table;
        i_cpu.tbl(1'b1, 6'h10, 16'h1234, q, n);
        i_cpu.tbl(1'b1, 6'h11, 16'h1004, q, n);
        i_cpu.tbl(1'b0, 6'h10, 16'h0000, q, n);
        `CHK({q, n}, {17'h11234, 1'b0})
        i_cpu.set_mode(1'b0);
        i_cpu.tbl(1'b0, 6'h10, 16'h0000, q, n);
        `CHK({q[15:0], n}, {16'h0000, 1'b1})
        i_cpu.tbl(1'b1, 6'h10, 16'hFFFF, q, n);
        `CHK(n, 1'b1)
        i_cpu.tbl(1'b1, mmu_pkg::IDX_CTRL, 16'h0001, q, n);
        `CHK({mmu_enabled, n}, 2'b01)
        i_cpu.set_mode(1'b1);
        i_cpu.tbl(1'b0, 6'h10, 16'h0000, q, n);
        `CHK({q, n}, {17'h11234, 1'b0})
    endtask
    task automatic t_xlate;
        i_cpu.tbl(1'b1, mmu_pkg::IDX_CTRL, 16'h0001, q, n);
        `CHK(mmu_enabled, 1'b1)
        i_cpu.acc(1'b0, 1'b0, 16'h1256, st, pa, n);
        `CHK({st, pa, n}, {2'b11, 24'h123656, 1'b0})
        i_cpu.acc(1'b0, 1'b0, 16'h13FF, st, pa, n);
        `CHK({st, pa, n}, {2'b11, 24'h1237FF, 1'b0})
        i_cpu.acc(1'b0, 1'b0, 16'h1400, st, pa, n);
        `CHK({st, n}, {2'b10, 1'b1})
        i_cpu.acc(1'b1, 1'b0, 16'h1256, st, pa, n);
        `CHK({st, n}, {2'b10, 1'b1})
        i_cpu.tbl(1'b1, 6'h0E, 16'hABCD, q, n);
        i_cpu.tbl(1'b1, 6'h0F, 16'h1201, q, n);
        i_cpu.set_mode(1'b0);
        i_cpu.acc(1'b1, 1'b0, 16'h1256, st, pa, n);
        `CHK({st, pa, n}, {2'b11, 24'hABCD56, 1'b0})
        i_cpu.acc(1'b0, 1'b0, 16'h1256, st, pa, n);
        `CHK({st, n}, {2'b10, 1'b1})
    endtask
    task automatic t_sfr;
        i_cpu.set_mode(1'b1);
        i_cpu.tbl(1'b1, mmu_pkg::IDX_SFR_LO, 16'h0004, q, n);
        i_cpu.tbl(1'b1, mmu_pkg::IDX_SFR_HI, 16'h0001, q, n);
        i_cpu.set_mode(1'b0);
        i_cpu.acc(1'b0, 1'b1, 16'h0009, st, pa, n);
        `CHK({st, pa, n}, {2'b11, 24'h000009, 1'b0})
        i_cpu.acc(1'b0, 1'b1, 16'h0041, st, pa, n);
        `CHK({st, pa, n}, {2'b11, 24'h000041, 1'b0})
        i_cpu.acc(1'b0, 1'b1, 16'h000C, st, pa, n);
        `CHK({st, n}, {2'b10, 1'b1})
        i_cpu.set_mode(1'b1);
        i_cpu.acc(1'b0, 1'b1, 16'h000C, st, pa, n);
        `CHK({st, pa, n}, {2'b11, 24'h00000C, 1'b0})
    endtask
    // a reset in mid-run must drop back to transparent mode with an empty table
    task automatic t_reset;
        @(negedge clk_sys);
        resetn = 1'b0;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        resetn = 1'b1;
        `CHK({mmu_enabled, ans_valid, nmi, tbl_rvalid}, 4'h0)
        i_cpu.set_mode(1'b0);
        i_cpu.acc(1'b0, 1'b0, 16'h1400, st, pa, n);
        `CHK({st, pa, n}, {2'b11, 24'h001400, 1'b0})
        i_cpu.set_mode(1'b1);
        i_cpu.tbl(1'b0, 6'h10, 16'h0000, q, n);
        `CHK({q, n}, {17'h10000, 1'b0})
    endtask
    initial begin
        resetn = 1'b0;
        repeat (12) @(posedge clk_sys);
        @(negedge clk_sys);
        resetn = 1'b1;
        t_transparent();
        t_table();
        t_xlate();
        t_sfr();
        t_reset();
        end_sim();
    end
endmodule // mmu_address_translation_protection_tb

// ---- mmu_cpu_model.sv ----
module mmu_cpu_model (
    // clock
    input  wire logic                        clk_sys,
    // access request
    output logic                             acc_req,
    output logic                             acc_code,
    output logic                             acc_sfr,
    output logic [mmu_pkg::LOG_AW-1:0]       log_addr,
    output logic                             irq_level,
    // answer
    input  wire logic                        ans_valid,
    input  wire logic                        acc_grant,
    input  wire logic [mmu_pkg::PHYS_AW-1:0] phys_addr,
    input  wire logic                        nmi,
    // table port
    output logic                             tbl_wr,
    output logic                             tbl_rd,
    output logic [mmu_pkg::TBL_IW-1:0]       tbl_idx,
    output logic [mmu_pkg::TBL_DW-1:0]       tbl_wdata,
    input  wire logic [mmu_pkg::TBL_DW-1:0]  tbl_rdata,
    input  wire logic                        tbl_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    // only the strobes and qualifiers start at a fixed level; mode and fields are set by the tasks
    initial begin
        {acc_req, acc_code, acc_sfr, tbl_wr, tbl_rd} = '0;
    end
    task automatic set_mode(input logic sys);
        @(negedge clk_sys);
        irq_level = sys;
    endtask
    // one access; returns {ans_valid, acc_grant}, phys_addr and nmi of the answer cycle
    task automatic acc(input logic code, input logic sfr, input logic [15:0] a,
                       output logic [1:0] st, output logic [23:0] pa, output logic n);
        @(negedge clk_sys);
        acc_req = 1'b1;
        acc_code = code;
        acc_sfr = sfr;
        log_addr = a;
        @(negedge clk_sys);
        acc_req = 1'b0;
        // released lines must not keep the old value, or a stale read could pass
        log_addr = ~a;
        st = {ans_valid, acc_grant};
        pa = phys_addr;
        n = nmi;
    endtask
    task automatic tbl(input logic wr, input logic [5:0] idx, input logic [15:0] d,
                       output logic [16:0] q, output logic n);
        @(negedge clk_sys);
        tbl_wr = wr;
        tbl_rd = ~wr;
        tbl_idx = idx;
        tbl_wdata = d;
        @(negedge clk_sys);
        {tbl_wr, tbl_rd} = 2'b00;
        tbl_idx = ~idx;
        tbl_wdata = ~d;
        q = {tbl_rvalid, tbl_rdata};
        n = nmi;
    endtask
endmodule // mmu_cpu_model

// ---- mmu_pkg.sv ----
package mmu_pkg;
    // address spaces
    localparam int LOG_AW  = 16;
    localparam int PHYS_AW = 24;
    localparam int PAGE_W  = 8;
    localparam int PPAGE_W = PHYS_AW - PAGE_W;
    localparam int LPAGE_W = LOG_AW - PAGE_W;

    // descriptor organisation: mode x kind x slot
    localparam int SLOTS   = 4;
    localparam int NDESC   = 2 * 2 * SLOTS;

    // configuration port indices
    localparam int TBL_IW  = 6;
    localparam int TBL_DW  = 16;
    localparam logic [5:0] IDX_CTRL     = 6'h20;
    localparam logic [5:0] IDX_SFR_LO   = 6'h21;
    localparam logic [5:0] IDX_SFR_HI   = 6'h22;
    localparam int         CTRL_EN_BIT  = 0;

    // reset values
    localparam logic [15:0] RST_WORD    = 16'h0000;
    localparam logic [31:0] RST_SFR     = 32'h0000_0000;

    // sfr permission grouping: one bit per group of four registers
    localparam int SFR_GRP_LSB = 2;
    localparam int SFR_GRP_W   = 5;
endpackage

// ---- mmu_unit.sv ----
// Notes on behaviour
// RL1: any violation raises non-maskable interrupt
// RL2: map 64 kByte logical to 16 MByte
// RL3: system mode at interrupt level, else application
// RL4: four data, four code descriptors per mode
// RL5: base and length in 256-byte pages
// RL6: two registers hold sfr access permissions
// RL7: outside descriptor range flags a violation
// RL8: only system mode reaches descriptor table
// RL9: transparent after reset until software enables
// RL10: physical equals base plus window offset
// RL11: application table write blocked and reported
module mmu_unit (
    // clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        resetn,
    // cpu access request
    input  wire logic                        acc_req,
    input  wire logic                        acc_code,
    input  wire logic                        acc_sfr,
    input  wire logic [mmu_pkg::LOG_AW-1:0]  log_addr,
    input  wire logic                        irq_level,
    // translated answer
    output logic                             ans_valid,
    output logic                             acc_grant,
    output logic [mmu_pkg::PHYS_AW-1:0]      phys_addr,
    output logic                             nmi,
    // descriptor table and control port
    input  wire logic                        tbl_wr,
    input  wire logic                        tbl_rd,
    input  wire logic [mmu_pkg::TBL_IW-1:0]  tbl_idx,
    input  wire logic [mmu_pkg::TBL_DW-1:0]  tbl_wdata,
    output logic [mmu_pkg::TBL_DW-1:0]       tbl_rdata,
    output logic                             tbl_rvalid,
    // state
    output logic                             mmu_enabled
);
    // word 0 of a descriptor: physical base page; word 1: {logical start page, length in pages}
    logic [mmu_pkg::PPAGE_W-1:0] desc_base [mmu_pkg::NDESC];
    logic [15:0]                 desc_win  [mmu_pkg::NDESC];
    logic [31:0]                 sfr_perm;
    logic                        sys_mode;
    logic                        tbl_ok;
    logic                        tbl_is_desc;
    logic [3:0]                  tbl_dsel;
    logic                        hit;
    logic [mmu_pkg::PPAGE_W:0]   next_page;
    logic                        sfr_ok;
    logic                        viol;
    logic                        tbl_viol;

    assign sys_mode    = irq_level; // RL3
    assign tbl_ok      = sys_mode; // RL8
    assign tbl_is_desc = (tbl_idx[5] == 1'b0);
    assign tbl_dsel    = tbl_idx[4:1];
    assign tbl_viol    = (tbl_wr || tbl_rd) && !tbl_ok; // RL11

    // descriptor lookup in the set owned by the current mode and access kind
    always_comb begin
        logic [3:0]                  di;
        logic [mmu_pkg::LPAGE_W-1:0] lp;
        logic [7:0]                  st;
        logic [7:0]                  ln;
        logic [7:0]                  dif;
        di        = 4'h0;
        lp        = log_addr[mmu_pkg::LOG_AW-1:mmu_pkg::PAGE_W];
        st        = 8'h00;
        ln        = 8'h00;
        dif       = 8'h00;
        hit       = 1'b0;
        next_page = '0;
        // lowest slot wins when windows overlap
        for (int k = mmu_pkg::SLOTS - 1; k >= 0; k--) begin
            di  = {sys_mode, acc_code, 2'(k)}; // RL4
            st  = desc_win[di][15:8]; // RL5
            ln  = desc_win[di][7:0];
            dif = lp - st;
            if (lp >= st && dif < ln) begin
                hit       = 1'b1;
                next_page = {1'b0, desc_base[di]} + {9'h000, dif}; // RL10
            end
        end
    end

    // application mode may only touch sfr groups it was granted
    assign sfr_ok = sys_mode || sfr_perm[log_addr[mmu_pkg::SFR_GRP_LSB +: mmu_pkg::SFR_GRP_W]]; // RL6

    // a page past the 16 MByte top counts as out of range too
    assign viol = mmu_enabled && (acc_sfr ? !sfr_ok : (!hit || next_page[mmu_pkg::PPAGE_W])); // RL7

    // enable bit
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            mmu_enabled <= 1'b0; // RL9
        end else if (tbl_wr && tbl_ok && tbl_idx == mmu_pkg::IDX_CTRL) begin
            mmu_enabled <= tbl_wdata[mmu_pkg::CTRL_EN_BIT]; // RL9
        end
    end

    // descriptor table writes, system mode only
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < mmu_pkg::NDESC; i++) begin
                desc_base[i] <= mmu_pkg::RST_WORD;
                desc_win[i]  <= mmu_pkg::RST_WORD;
            end
        end else if (tbl_wr && tbl_ok && tbl_is_desc) begin // RL8
            if (tbl_idx[0]) begin
                desc_win[tbl_dsel] <= tbl_wdata;
            end else begin
                desc_base[tbl_dsel] <= tbl_wdata;
            end
        end
    end

    // sfr permission pair
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sfr_perm <= mmu_pkg::RST_SFR;
        end else if (tbl_wr && tbl_ok) begin
            if (tbl_idx == mmu_pkg::IDX_SFR_LO) begin
                sfr_perm[15:0] <= tbl_wdata; // RL6
            end else if (tbl_idx == mmu_pkg::IDX_SFR_HI) begin
                sfr_perm[31:16] <= tbl_wdata; // RL6
            end
        end
    end

    // table reads: application mode sees zero so nothing leaks
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tbl_rdata  <= 16'h0000;
            tbl_rvalid <= 1'b0;
        end else begin
            tbl_rvalid <= tbl_rd;
            tbl_rdata  <= 16'h0000;
            if (tbl_rd && tbl_ok) begin // RL8
                if (tbl_is_desc) begin
                    tbl_rdata <= tbl_idx[0] ? desc_win[tbl_dsel] : desc_base[tbl_dsel];
                end else if (tbl_idx == mmu_pkg::IDX_CTRL) begin
                    tbl_rdata <= {15'h0000, mmu_enabled};
                end else if (tbl_idx == mmu_pkg::IDX_SFR_LO) begin
                    tbl_rdata <= sfr_perm[15:0];
                end else if (tbl_idx == mmu_pkg::IDX_SFR_HI) begin
                    tbl_rdata <= sfr_perm[31:16];
                end
            end
        end
    end

    // translated answer, one cycle after the request
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ans_valid <= 1'b0;
            acc_grant <= 1'b0;
            phys_addr <= 24'h00_0000;
        end else begin
            ans_valid <= acc_req;
            acc_grant <= acc_req && !viol;
            if (acc_req) begin
                if (!mmu_enabled || acc_sfr) begin
                    phys_addr <= {8'h00, log_addr}; // RL9
                end else begin
                    phys_addr <= {next_page[mmu_pkg::PPAGE_W-1:0], log_addr[mmu_pkg::PAGE_W-1:0]}; // RL2
                end
            end
        end
    end

    // nmi pulses for one cycle per offending access or table attempt
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            nmi <= 1'b0;
        end else begin
            nmi <= (acc_req && viol) || tbl_viol; // RL1
        end
    end

    property p_viol_nmi;
        @(posedge clk_sys) disable iff (!resetn)
        acc_req && viol |=> nmi && !acc_grant && ans_valid;
    endproperty
    a_viol_nmi: assert property (p_viol_nmi) else $error("violation without nmi"); // RL1

    property p_transparent;
        @(posedge clk_sys) disable iff (!resetn)
        acc_req && !mmu_enabled |=> acc_grant && phys_addr == {8'h00, $past(log_addr)};
    endproperty
    a_transparent: assert property (p_transparent) else $error("transparent mode altered access"); // RL9

    property p_page_offset;
        @(posedge clk_sys) disable iff (!resetn)
        acc_req |=> phys_addr[7:0] == $past(log_addr[7:0]);
    endproperty
    a_page_offset: assert property (p_page_offset) else $error("offset within page changed"); // RL5

    property p_grant_in_range;
        @(posedge clk_sys) disable iff (!resetn)
        acc_req && mmu_enabled && !acc_sfr && !hit |=> !acc_grant ##0 nmi;
    endproperty
    a_grant_in_range: assert property (p_grant_in_range) else $error("out of range access granted"); // RL7

    property p_sfr_perm;
        @(posedge clk_sys) disable iff (!resetn)
        acc_req && mmu_enabled && acc_sfr && !irq_level
            && !sfr_perm[log_addr[mmu_pkg::SFR_GRP_LSB +: mmu_pkg::SFR_GRP_W]] |=> nmi;
    endproperty
    a_sfr_perm: assert property (p_sfr_perm) else $error("sfr permission ignored"); // RL6

    property p_app_read;
        @(posedge clk_sys) disable iff (!resetn)
        tbl_rd && !irq_level |=> tbl_rvalid && tbl_rdata == 16'h0000 && nmi;
    endproperty
    a_app_read: assert property (p_app_read) else $error("application read the table"); // RL8

    property p_app_write;
        @(posedge clk_sys) disable iff (!resetn)
        tbl_wr && !irq_level && tbl_idx == mmu_pkg::IDX_CTRL |=> nmi && $stable(mmu_enabled);
    endproperty
    a_app_write: assert property (p_app_write) else $error("application write not blocked"); // RL11

    property p_sys_enable;
        @(posedge clk_sys) disable iff (!resetn)
        tbl_wr && irq_level && tbl_idx == mmu_pkg::IDX_CTRL |=> mmu_enabled == $past(tbl_wdata[0]) && !nmi;
    endproperty
    a_sys_enable: assert property (p_sys_enable) else $error("system write to control lost"); // RL3

    property p_translate;
        @(posedge clk_sys) disable iff (!resetn)
        acc_req && mmu_enabled && !acc_sfr && hit && !next_page[16] |=>
            acc_grant && phys_addr[23:8] == $past(next_page[15:0]);
    endproperty
    a_translate: assert property (p_translate) else $error("translation not applied"); // RL10
endmodule // mmu_unit
